// >>> polseq_map.svh
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef POLSEQ_MAP_SVH
`define POLSEQ_MAP_SVH
`define POLSEQ_CLK_KHZ 100000
`define POLSEQ_T_MS 1
`define POLSEQ_CYC_PER_MS (`POLSEQ_CLK_KHZ * `POLSEQ_T_MS)
`define POLSEQ_T_BOOT_MS 60
`define POLSEQ_T_PRERAMP_MS 2
`define POLSEQ_OSC_KHZ 16000
`define POLSEQ_N_MIN 20
`define POLSEQ_N_MAX 40
`define POLSEQ_N_DEFAULT 6'h1C
`define POLSEQ_FREQ_MIN_KHZ 571
`define POLSEQ_FREQ_MAX_KHZ 800
`define POLSEQ_REF_LO_CYC 8'h71
`define POLSEQ_REF_HI_CYC 8'hC1
`define POLSEQ_SHARE_PULSE 8'h10
`define POLSEQ_ADDR_CTRL 8'h00
`define POLSEQ_ADDR_FREQ 8'h04
`define POLSEQ_ADDR_CH1 8'h08
`define POLSEQ_ADDR_CH2 8'h0C
`define POLSEQ_ADDR_STAT 8'h10
`define POLSEQ_CTRL_SYNC_OUT 0
`define POLSEQ_CTRL_PROG_FREQ 1
`define POLSEQ_CTRL_FLT_SHUT 2
`define POLSEQ_CTRL_RESTART 3
`define POLSEQ_CTRL_PEER_SHUT 4
`define POLSEQ_CTRL_RESET 32'h0000_0000
`define POLSEQ_FREQ_RESET 16'h023B
`define POLSEQ_CH1_RESET 32'h0100_0A05
`define POLSEQ_CH2_RESET 32'h0100_050A
`endif

// >>> polseq_pkg.sv
// Types shared by the sequencer top and its channel engine
package polseq_pkg;
   typedef enum logic [2:0] {
      CH_OFF, CH_WAIT, CH_RISE, CH_ON, CH_TOFF, CH_FALL, CH_HALT
   } polseq_state_e;
   typedef struct packed {
      logic [7:0] fall_ms;
      logic [7:0] toff_ms;
      logic [7:0] rise_ms;
      logic [7:0] ton_ms;
   } polseq_timing_s;
   typedef struct packed {
      logic run;
      logic ramp;
      logic good;
      polseq_state_e state;
   } polseq_chstat_s;
endpackage

// >>> polseq_channel.sv
// One output channel: enable edge detection, delay, ramp and power-good
`timescale 1ns/1ps
`default_nettype none
`include "polseq_map.svh"
module polseq_channel
   import polseq_pkg::*;
#(
   parameter int MS_CYCLES = `POLSEQ_CYC_PER_MS
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic ready_i,
   input wire logic en_i,
   input wire polseq_timing_s cfg_i,
   input wire logic stop_i,
   input wire logic restart_i,
   input wire logic in_window_i,
   input wire logic fault_i,
   output polseq_chstat_s stat_o
);
   polseq_state_e st_q, st_d;
   logic en_q;
   logic [16:0] cyc_q;
   logic [7:0] ms_q;
   logic [7:0] tgt;
   logic done;
   wire en_rise = en_i & ~en_q;
   wire en_fall = ~en_i & en_q;
   wire tick = (cyc_q == 17'(MS_CYCLES - 1));

   // Delay target of the current state; the turn-on wait never drops below the pre-ramp
   always_comb begin
      case (st_q)
         CH_WAIT: tgt = (cfg_i.ton_ms < 8'(`POLSEQ_T_PRERAMP_MS)) ?
                        8'(`POLSEQ_T_PRERAMP_MS) : cfg_i.ton_ms; // [RULE17]
         CH_RISE: tgt = cfg_i.rise_ms;
         CH_TOFF: tgt = cfg_i.toff_ms;
         CH_FALL: tgt = cfg_i.fall_ms;
         default: tgt = 8'h00;
      endcase
   end
   assign done = (ms_q >= tgt);

   // Edges are acted on only in settled states; a short pulse is lost on purpose
   always_comb begin
      st_d = st_q;
      case (st_q)
         CH_OFF:  if (en_rise && ready_i && !stop_i) st_d = CH_WAIT; // [RULE11] [RULE16]
         CH_WAIT: if (done) st_d = CH_RISE; // [RULE18]
         CH_RISE: if (done) st_d = CH_ON;
         CH_ON:   if (en_fall) st_d = CH_TOFF; // [RULE11] [RULE20]
         CH_TOFF: if (done) st_d = CH_FALL; // [RULE20]
         CH_FALL: if (done) st_d = CH_OFF;
         CH_HALT: if (!stop_i) st_d = (restart_i && en_i) ? CH_WAIT : CH_OFF; // [RULE15]
         default: st_d = CH_OFF;
      endcase
      if (stop_i && st_q != CH_OFF) st_d = CH_HALT; // [RULE15]
   end

   // Own millisecond timer, restarted on every state change so channels never interact
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= CH_OFF;
         en_q <= 1'b0;
         cyc_q <= 17'h00000;
         ms_q <= 8'h00;
      end else begin
         st_q <= st_d;
         en_q <= en_i; // [RULE22]
         cyc_q <= (st_d != st_q || tick) ? 17'h00000 : cyc_q + 17'h00001;
         ms_q <= (st_d != st_q) ? 8'h00 : (tick && ms_q != 8'hFF) ? ms_q + 8'h01 : ms_q;
      end
   end

   // Flags registered so the top can pass them to pins untouched
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stat_o <= '{run: 1'b0, ramp: 1'b0, good: 1'b0, state: CH_OFF};
      end else begin
         stat_o.run <= (st_d inside {CH_RISE, CH_ON, CH_TOFF, CH_FALL});
         stat_o.ramp <= (st_d inside {CH_RISE, CH_FALL});
         stat_o.good <= (st_d == CH_ON) && in_window_i && !fault_i; // [RULE14]
         stat_o.state <= st_d;
      end
   end

   AST_PRERAMP: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE17]
      (st_q == CH_WAIT && st_d == CH_RISE) |-> ms_q >= 8'(`POLSEQ_T_PRERAMP_MS))
      else $error("ramp started before the pre-ramp time");
   AST_GOOD_CLEAN: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE14]
      stat_o.good |-> $past(in_window_i) && !$past(fault_i) && stat_o.state == CH_ON)
      else $error("power good without a clean output");
   AST_HALT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE15]
      (stop_i && st_q != CH_OFF) |=> st_q == CH_HALT ##1 !stat_o.run)
      else $error("channel kept running on a fault stop");
endmodule
`default_nettype wire

// >>> polseq_top.sv
// Sequencer top: clock selection, reference lock, share bus faults and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "polseq_map.svh"
// How it works
// [RULE1] Default switching rate is 571 kHz; selectable range spans 571 to 800 kHz; programmed requests reach down to 400 kHz (N of 40).
// [RULE2] Strap code picks 571, 615, 727 or 800 kHz.
// [RULE3] Reference pin leaves reset as an input; output mode only with internal oscillator.
// [RULE4] Every enable edge starts a search for a reference clock to lock onto; the code searches only on a rising enable edge while not locked.
// [RULE5] Outside party supplies a stable 571-800 kHz reference before enabling.
// [RULE6] Reference stays within 10% of start and pulses last 150 ns or more.
// [RULE7] Losing the reference falls back to the internal oscillator at programmed rate.
// [RULE8] Output mode drives the internal clock out and skips the reference search.
// [RULE9] Internal rate is 16 MHz divided by N, N from 20 to 40.
// [RULE10] Requested rate maps to the nearest N, clamped to the range.
// [RULE11] Enables act on edges; short pulses may be ignored.
// [RULE12] Outside party keeps enable pulses longer than the sequence times plus margin.
// [RULE13] Outside party drives enables without bounce.
// [RULE14] Power good only while in tolerance and without fault.
// [RULE15] With fault shutdown set, stop and broadcast; peers stop, restart if allowed.
// [RULE16] After power-up, 60 ms pass before commands or enables are accepted.
// [RULE17] At least 2 ms pass between enable and the ramp start.
// [RULE18] Ramp begins when the turn-on delay expires and lasts the rise time.
// [RULE19] Default turn-on delays are 5 ms and 10 ms for channels one and two.
// [RULE20] Disable stops quickly after the turn-off delay; small channel skew allowed.
// [RULE21] Outside party keeps enables low over 110 ms during power-up.
// [RULE22] Each channel has its own edge detector and timers.
module polseq_top
   import polseq_pkg::*;
#(
   parameter int MS_CYCLES = `POLSEQ_CYC_PER_MS
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic channel1_enable_i,
   input wire logic channel2_enable_i,
   input wire logic strap_fitted_i,
   input wire logic [1:0] freq_strap_i,
   input wire logic [1:0] out_in_window_i,
   input wire logic [1:0] out_fault_i,
   input wire logic sync_i,
   output logic sync_o,
   output logic sync_oe_o,
   input wire logic share_bus_n_i,
   output logic share_bus_n_o,
   output logic share_bus_oe_o,
   output logic sw_clk_o,
   output logic [1:0] switch_run_o,
   output logic channel1_output_good_o,
   output logic channel2_output_good_o
);
   localparam logic [7:0] BOOT_MS = 8'(`POLSEQ_T_BOOT_MS);

   // Register state
   logic [31:0] ctrl_q;
   logic [15:0] freq_q;
   polseq_timing_s tim_q [2];
   logic ready_q, locked_q, arm_q;
   logic [16:0] pre_q;
   logic [7:0] boot_q;
   logic [1:0] strap_q;
   logic strap_ok_q, strap_seen_q;

   // Boot timer: enables and writes are refused until configuration load ends
   wire pre_tick = (pre_q == 17'(MS_CYCLES - 1));
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre_q <= 17'h00000;
         boot_q <= 8'h00;
         ready_q <= 1'b0;
      end else begin
         pre_q <= pre_tick ? 17'h00000 : pre_q + 17'h00001;
         if (pre_tick && !ready_q) boot_q <= boot_q + 8'h01;
         ready_q <= ready_q | (boot_q >= BOOT_MS); // [RULE16]
      end
   end

   // Strap levels caught once after reset release, never under reset
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         strap_seen_q <= 1'b0;
         strap_ok_q <= 1'b0;
         strap_q <= 2'h0;
      end else if (!strap_seen_q) begin
         strap_seen_q <= 1'b1;
         strap_ok_q <= strap_fitted_i;
         strap_q <= freq_strap_i;
      end
   end

   // Nearest divisor: count midpoint thresholds that the request sits at or below
   function automatic logic [15:0] mid_khz(input int k);
      return 16'((`POLSEQ_OSC_KHZ / 2) * (2 * k + 1) / (k * (k + 1)));
   endfunction
   logic [19:0] below;
   genvar gk;
   generate
      for (gk = 0; gk < 20; gk++) begin : g_thr
         assign below[gk] = (freq_q <= mid_khz(gk + `POLSEQ_N_MIN)); // [RULE10]
      end
   endgenerate
   logic [5:0] n_prog;
   always_comb begin
      n_prog = 6'(`POLSEQ_N_MIN);
      for (int i = 0; i < 20; i++) n_prog = n_prog + 6'(below[i]); // [RULE9] [RULE10]
   end
   logic [5:0] n_strap;
   always_comb begin
      case (strap_q)
         2'h0: n_strap = 6'h1C;
         2'h1: n_strap = 6'h1A;
         2'h2: n_strap = 6'h16;
         default: n_strap = 6'h14;
      endcase // [RULE2]
   end
   wire [5:0] n_sel = ctrl_q[`POLSEQ_CTRL_PROG_FREQ] ? n_prog :
                      strap_ok_q ? n_strap : `POLSEQ_N_DEFAULT; // [RULE1]

   // Internal oscillator: 16 MHz enable from a fractional step, then divide by N
   logic [6:0] acc_q;
   logic [5:0] div_q;
   wire [7:0] acc_sum = {1'b0, acc_q} + 8'h10;
   wire osc_tick = (acc_sum >= 8'h64);
   wire int_clk = (div_q < {1'b0, n_sel[5:1]});
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_q <= 7'h00;
         div_q <= 6'h00;
      end else begin
         acc_q <= osc_tick ? 7'(acc_sum - 8'h64) : acc_sum[6:0];
         if (osc_tick) div_q <= (div_q >= n_sel - 6'h01) ? 6'h00 : div_q + 6'h01; // [RULE9]
      end
   end

   // Reference search and lock: one period within the accepted band locks
   logic sync_q, en1_q, en2_q;
   logic [7:0] per_q;
   wire sync_out = ctrl_q[`POLSEQ_CTRL_SYNC_OUT];
   wire ref_edge = sync_i & ~sync_q;
   wire en_edge = (channel1_enable_i & ~en1_q) | (channel2_enable_i & ~en2_q);
   wire per_ok = (per_q >= `POLSEQ_REF_LO_CYC) && (per_q <= `POLSEQ_REF_HI_CYC);
   wire per_lost = (per_q > `POLSEQ_REF_HI_CYC);
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_q <= 1'b0;
         en1_q <= 1'b0;
         en2_q <= 1'b0;
         per_q <= 8'hFF;
         arm_q <= 1'b0;
         locked_q <= 1'b0;
      end else begin
         sync_q <= sync_i;
         en1_q <= channel1_enable_i;
         en2_q <= channel2_enable_i;
         per_q <= ref_edge ? 8'h00 : (per_q == 8'hFF) ? per_q : per_q + 8'h01;
         if (sync_out) begin
            arm_q <= 1'b0; // [RULE8]
            locked_q <= 1'b0;
         end else if (en_edge && !locked_q) begin
            arm_q <= 1'b1; // [RULE4]
         end else if (locked_q) begin
            if (per_lost || (ref_edge && !per_ok)) locked_q <= 1'b0; // [RULE7]
         end else if (arm_q && ref_edge && per_ok) begin
            locked_q <= 1'b1; // [RULE4]
            arm_q <= 1'b0;
         end else if (arm_q && per_q == 8'hFF) begin
            arm_q <= 1'b0;
         end
      end
   end

   // Switching clock and reference pin; locked copies the reference pin level, both edges, one cycle late
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sw_clk_o <= 1'b0;
         sync_o <= 1'b0;
         sync_oe_o <= 1'b0; // [RULE3]
      end else begin
         sw_clk_o <= locked_q ? sync_i : int_clk; // [RULE4] [RULE7]
         sync_o <= sync_out & int_clk; // [RULE8]
         sync_oe_o <= sync_out;
      end
   end

   // Share bus: a local fault is broadcast by pulling the line low for a short pulse
   polseq_chstat_s chs [2];
   logic [7:0] bc_q;
   logic peer_q;
   wire flt_shut = ctrl_q[`POLSEQ_CTRL_FLT_SHUT];
   wire local_flt = flt_shut && |(out_fault_i & {chs[1].run, chs[0].run});
   wire peer_flt = !share_bus_n_i && !share_bus_oe_o && ctrl_q[`POLSEQ_CTRL_PEER_SHUT];
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bc_q <= 8'h00;
         peer_q <= 1'b0;
         share_bus_n_o <= 1'b1;
         share_bus_oe_o <= 1'b0;
      end else begin
         if (local_flt) bc_q <= `POLSEQ_SHARE_PULSE; // [RULE15]
         else if (bc_q != 8'h00) bc_q <= bc_q - 8'h01;
         peer_q <= peer_flt; // [RULE15]
         share_bus_n_o <= 1'b0;
         share_bus_oe_o <= local_flt || (bc_q > 8'h01);
      end
   end
   wire stop_all = local_flt || peer_q || (bc_q != 8'h00);

   // Two independent channel engines
   wire [1:0] en_v = {channel2_enable_i, channel1_enable_i};
   genvar gc;
   generate
      for (gc = 0; gc < 2; gc++) begin : g_ch
         polseq_channel #(.MS_CYCLES(MS_CYCLES)) u_ch ( // [RULE22]
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .ready_i(ready_q),
            .en_i(en_v[gc]),
            .cfg_i(tim_q[gc]),
            .stop_i(stop_all),
            .restart_i(ctrl_q[`POLSEQ_CTRL_RESTART]),
            .in_window_i(out_in_window_i[gc]),
            .fault_i(out_fault_i[gc]),
            .stat_o(chs[gc])
         );
      end
   endgenerate
   assign switch_run_o = {chs[1].run, chs[0].run};
   assign channel1_output_good_o = chs[0].good; // [RULE14]
   assign channel2_output_good_o = chs[1].good;

   // AXI4-Lite write: address and data taken in either order, response after both
   logic aw_full_q, w_full_q;
   logic [7:0] aw_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   wire wr_go = aw_full_q && w_full_q && !s_axi_bvalid_o;
   wire wr_map = (aw_q == `POLSEQ_ADDR_CTRL) || (aw_q == `POLSEQ_ADDR_FREQ) ||
                 (aw_q == `POLSEQ_ADDR_CH1) || (aw_q == `POLSEQ_ADDR_CH2);
   wire wr_ok = wr_go && wr_map && ready_q; // [RULE16]
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int b = 0; b < 4; b++) if (be[b]) old[8*b +: 8] = nw[8*b +: 8];
      return old;
   endfunction
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= 2'h0;
      end else begin
         s_axi_awready_o <= !aw_full_q && !s_axi_awready_o;
         s_axi_wready_o <= !w_full_q && !s_axi_wready_o;
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_full_q <= 1'b1;
            aw_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_full_q <= 1'b1;
            wd_q <= s_axi_wdata_i;
            ws_q <= s_axi_wstrb_i;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // Register storage with byte strobes; turn-on defaults order the two channels
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q <= `POLSEQ_CTRL_RESET; // [RULE3]
         freq_q <= `POLSEQ_FREQ_RESET; // [RULE1]
         tim_q[0] <= `POLSEQ_CH1_RESET; // [RULE19]
         tim_q[1] <= `POLSEQ_CH2_RESET; // [RULE19]
      end else if (wr_ok) begin
         case (aw_q)
            `POLSEQ_ADDR_CTRL: ctrl_q <= merge(ctrl_q, wd_q, ws_q) & 32'h0000_001F;
            `POLSEQ_ADDR_FREQ: freq_q <= 16'(merge({16'h0000, freq_q}, wd_q, ws_q));
            `POLSEQ_ADDR_CH1: tim_q[0] <= merge(tim_q[0], wd_q, ws_q);
            `POLSEQ_ADDR_CH2: tim_q[1] <= merge(tim_q[1], wd_q, ws_q);
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // AXI4-Lite read: one read at a time, status shows live sequencer state
   wire [31:0] stat_w = {18'h0, switch_run_o,
                         chs[1].good, chs[0].good, n_sel, 1'b0, sync_out, locked_q, ready_q};
   logic [31:0] rd_mux;
   always_comb begin
      case (s_axi_araddr_i)
         `POLSEQ_ADDR_CTRL: rd_mux = ctrl_q;
         `POLSEQ_ADDR_FREQ: rd_mux = {16'h0000, freq_q};
         `POLSEQ_ADDR_CH1: rd_mux = tim_q[0];
         `POLSEQ_ADDR_CH2: rd_mux = tim_q[1];
         `POLSEQ_ADDR_STAT: rd_mux = stat_w;
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   wire rd_map = (s_axi_araddr_i <= `POLSEQ_ADDR_STAT) && (s_axi_araddr_i[1:0] == 2'h0);
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= 2'h0;
      end else begin
         s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o;
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_mux;
            s_axi_rresp_o <= rd_map ? 2'h0 : 2'h2;
         end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

   // Checks next to the logic above
   sequence s_ref_edge_ok;
      ref_edge && per_ok && arm_q && !sync_out;
   endsequence
   sequence s_ref_gone;
      locked_q && per_lost;
   endsequence
   AST_LOCK: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE4]
      s_ref_edge_ok |=> locked_q ##1 (sw_clk_o == $past(sync_i)))
      else $error("reference not followed after a good period");
   AST_FALLBACK: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE7]
      s_ref_gone |=> !locked_q ##1 (sw_clk_o == $past(int_clk)))
      else $error("no fallback to the internal oscillator");
   AST_OUT_MODE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE8]
      sync_out |=> sync_oe_o && !locked_q && !arm_q)
      else $error("output mode still searching for a reference");
   AST_PIN_INPUT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE3]
      !$past(sync_out) |-> !sync_oe_o)
      else $error("reference pin driven while configured as input");
   AST_N_RANGE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE9]
      n_sel >= 6'h14 && n_sel <= 6'h28)
      else $error("divisor outside 20 to 40");
   AST_N_DEFAULT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE1]
      (!ctrl_q[1] && !strap_ok_q) |-> n_sel == 6'h1C)
      else $error("default rate is not 571 kHz");
   AST_BOOT: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE16]
      !ready_q |-> !s_axi_bvalid_o || s_axi_bresp_o == 2'h2 || !$rose(s_axi_bvalid_o)
      ##0 switch_run_o == 2'b00)
      else $error("activity before the boot time ended");
   AST_BROADCAST: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // [RULE15]
      local_flt |=> share_bus_oe_o && !share_bus_n_o ##2 switch_run_o == 2'b00)
      else $error("fault not broadcast or channels not stopped");
endmodule
`default_nettype wire

// >>> polseq_ref_model.sv
// Reference clock source of the system controller; still while not running
`timescale 1ns/1ps
`default_nettype none
module polseq_ref_model #(
   parameter int HALF_CYC = 70
) (
   input wire logic clk_sys_i,
   input wire logic run_i,
   output logic sync_o = 1'b0
);
   int cnt = 0;
   // Fixed half period: steady rate in band, clean pulses far above 150 ns
   always @(posedge clk_sys_i) begin
      if (run_i) begin
         cnt <= (cnt == HALF_CYC - 1) ? 0 : cnt + 1;
         if (cnt == HALF_CYC - 1) sync_o <= ~sync_o;
      end
   end
endmodule
`default_nettype wire

// >>> pol_enable_seq_and_clock_select_tb.sv
// Self-checking bench of the sequencer top with a reference clock partner
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module pol_enable_seq_and_clock_select_tb;
   import polseq_pkg::*;
   localparam int MSC = 100;
   logic clk_sys_i = 0, nrst_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdata, rd;
   logic awr, wr_r, bv, arr, rv, syo, syoe, swc, pg1, pg2, s, syw, ref_s, sh_n, sh_oe, sh_do;
   logic [1:0] bresp, rresp, rsp, run, win = 2'h0, flt = 2'h0, strap = 2'h0;
   logic en1 = 0, en2 = 0, fit = 0, ref_run = 0, peer = 0;
   int error_cnt = 0, compares = 0, cyc = 0, c0, t1, t2, g1, g2, f;
   int fq[4] = '{571, 615, 727, 800};
   logic [31:0] rst_v[4] = '{32'h0, 32'h23B, 32'h0100_0A05, 32'h0100_050A};
   int unsigned rs = 71;
   // Pin levels: sync driven by whoever enables it, share line pulled up, pulled low by us or a peer
   assign syw = syoe ? syo : ref_s;
   assign sh_n = !((sh_oe && !sh_do) || peer);
   polseq_top #(.MS_CYCLES(MSC)) uut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
      .channel1_enable_i(en1), .channel2_enable_i(en2), .strap_fitted_i(fit),
      .freq_strap_i(strap), .out_in_window_i(win), .out_fault_i(flt), .sync_i(syw),
      .sync_o(syo), .sync_oe_o(syoe), .share_bus_n_i(sh_n), .share_bus_n_o(sh_do),
      .share_bus_oe_o(sh_oe), .sw_clk_o(swc), .switch_run_o(run),
      .channel1_output_good_o(pg1), .channel2_output_good_o(pg2));
   polseq_ref_model ref_m (.clk_sys_i(clk_sys_i), .run_i(ref_run), .sync_o(ref_s));
   // Clock and hang guard
   always #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 90000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   // Divider whose 16 MHz rate lies nearest the request, clamped to 20..40
   function automatic int exp_n(input int fk);
      int q;
      q = 16000 / fk;
      if (16000 * (2 * q + 1) > 2 * fk * q * (q + 1)) q++;
      return q < 20 ? 20 : (q > 40 ? 40 : q);
   endfunction
   function automatic int unsigned xs(input int unsigned x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // Each channel is released when taken; response waits for bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      do begin
         @(posedge clk_sys_i);
         if (awr) awv <= 0;
         if (wr_r) wv <= 0;
      end while (!bv);
      rsp = bresp;
      bry <= 0;
   endtask
   task automatic rd_t(input logic [7:0] a);
      @(posedge clk_sys_i);
      ara <= a;
      arv <= 1;
      rry <= 1;
      do begin
         @(posedge clk_sys_i);
         if (arr) arv <= 0;
      end while (!rv);
      rd = rdata;
      rsp = rresp;
      rry <= 0;
   endtask
   task automatic poll(input int b, input logic v);
      int k;
      k = 0;
      do begin
         rd_t(8'h10);
         k++;
      end while (rd[b] !== v && k < 4000);
      `CHK("poll", v, rd[b])
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      for (int i = 0; i < 5; i++) begin
         nrst_i <= 0;
         fit <= (i < 4);
         strap <= 2'(i);
         repeat (16) @(posedge clk_sys_i);
         nrst_i <= 1;
         c0 = cyc;
         wr(8'h0C, 32'h0);
         `CHK("boot_wr", 2'h2, rsp)
         poll(0, 1);
         `CHK("boot_len", 1, (cyc - c0) >= 60 * MSC)
         `CHK("n_used", exp_n(i < 4 ? fq[i] : 571), rd[9:4])
      end
      $display("test strap and boot done");
      for (int i = 0; i < 4; i++) begin
         rd_t(8'(4 * i));
         `CHK("reg_rst", rst_v[i], rd)
      end
      `CHK("sync_oe", 1'b0, syoe)
      rd_t(8'h20);
      `CHK("unmapped", 2'h2, rsp)
      wr(8'h00, 32'h2);
      for (int k = 0; k < 6; k++) begin
         rs = xs(rs);
         f = k == 0 ? 810 : (k == 1 ? 400 : 571 + rs % 230);
         wr(8'h04, 32'(f));
         rd_t(8'h10);
         `CHK("n_prog", exp_n(f), rd[9:4])
      end
      $display("test divider done");
      ref_run <= 1;
      win <= 2'h3;
      repeat (400) @(posedge clk_sys_i);
      en1 <= 1;
      en2 <= 1;
      t1 = 0;
      t2 = 0;
      g1 = 0;
      g2 = 0;
      for (int c = 1; c < 2000; c++) begin
         @(posedge clk_sys_i);
         if (t1 == 0 && run[0]) t1 = c;
         if (t2 == 0 && run[1]) t2 = c;
         if (g1 == 0 && pg1) g1 = c;
         if (g2 == 0 && pg2) g2 = c;
      end
      `CHK("ton1", 1, t1 >= 5 * MSC && t1 <= 5 * MSC + 6)
      `CHK("ton2", 1, t2 >= 10 * MSC && t2 <= 10 * MSC + 6)
      `CHK("rise1", 1, g1 - t1 >= 10 * MSC && g1 - t1 <= 10 * MSC + 6)
      `CHK("rise2", 1, g2 - t2 >= 5 * MSC && g2 - t2 <= 5 * MSC + 6)
      rd_t(8'h10);
      `CHK("locked", 1'b1, rd[1])
      for (int c = 0; c < 300; c++) begin
         s = syw;
         @(posedge clk_sys_i);
         `CHK("sw_clk", s, swc)
      end
      win <= 2'h2;
      repeat (4) @(posedge clk_sys_i);
      `CHK("pg1_off", 1'b0, pg1)
      `CHK("pg2_on", 1'b1, pg2)
      en1 <= 0;
      t1 = 0;
      for (int c = 1; c < 300 && t1 == 0; c++) begin
         @(posedge clk_sys_i);
         if (!run[0]) t1 = c;
      end
      `CHK("toff1", 1, t1 >= MSC && t1 <= MSC + 8)
      `CHK("run2", 1'b1, run[1])
      $display("test sequencing done");
      ref_run <= 0;
      repeat (400) @(posedge clk_sys_i);
      rd_t(8'h10);
      `CHK("unlock", 1'b0, rd[1])
      `CHK("n_fallbk", exp_n(f), rd[9:4])
      wr(8'h00, 32'h6);
      flt <= 2'h2;
      repeat (3) @(posedge clk_sys_i);
      `CHK("share_oe", 1'b1, sh_oe)
      `CHK("share_lvl", 1'b0, sh_n)
      repeat (4) @(posedge clk_sys_i);
      `CHK("halt2", 1'b0, run[1])
      `CHK("pg2_flt", 1'b0, pg2)
      flt <= 2'h0;
      wr(8'h00, 32'h1);
      repeat (2) @(posedge clk_sys_i);
      `CHK("sync_out", 1'b1, syoe)
      @(posedge syo);
      c0 = cyc;
      @(posedge syo);
      `CHK("sync_per", exp_n(571), ((cyc - c0) * 16 + 50) / 100)
      wr(8'h00, 32'h1E);
      repeat (700) @(posedge clk_sys_i);
      en1 <= 1;
      repeat (600) @(posedge clk_sys_i);
      peer <= 1;
      repeat (4) @(posedge clk_sys_i);
      `CHK("peer_halt", 2'h0, run)
      peer <= 0;
      repeat (600) @(posedge clk_sys_i);
      `CHK("restart", 2'h1, run)
      $display("test fault and pin mode done");
      report_and_stop();
   end
endmodule
`default_nettype wire
